// >>> design/channel_current_tracker.sv
// one channel: refreshes, clears or holds its current result, times disconnect
`timescale 1ns/1ps
`default_nettype none
`include "telemetry_consts.svh"

module channel_current_tracker
  import telemetry_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  // channel status and measurement
  input  wire telemetry_pkg::chan_status_t status,
  input  wire logic                      disconnect_threshold_select,
  input  wire logic [`RESULT_WIDTH-1:0]  adc_code,
  input  wire logic                      refresh_tick,
  // results
  output logic      [`RESULT_WIDTH-1:0]  current_result,
  output logic                           disconnect_req
);

  // ***************************************************************
  // state
  // ***************************************************************
  logic [`RESULT_WIDTH-1:0] next_current_result;   // result next cycle
  logic                     enabled_once;          // channel powered at least once
  logic                     next_enabled_once;
  logic [31:0]              low_count;             // cycles spent below threshold
  logic [31:0]              next_low_count;
  logic                     next_disconnect_req;
  logic                     below_thr;             // threshold chosen by select bit
  logic                     force_zero;            // result must read zero

  // ***************************************************************
  // next-value logic
  // ***************************************************************
  always_comb
  begin
    // 4.5 mA when the select bit is set, 6.5 mA when cleared
    below_thr = disconnect_threshold_select ? status.below_low_thr
                                            : status.below_high_thr;
    // off, or semi-auto unpowered with no det/class or bad detection
    force_zero = (status.mode == MODE_OFF) ||
                 ((status.mode == MODE_SEMI_AUTO) && !status.powered &&
                  (!status.det_class_enable || !status.detect_valid));
    next_enabled_once   = enabled_once | status.powered;
    next_current_result = current_result;
    if (force_zero)
    begin
      next_current_result = `RESULT_RESET;
    end
    else if (status.powered && refresh_tick)
    begin
      next_current_result = adc_code;
    end
    else if (!status.powered && !(status.mode == MODE_MANUAL && enabled_once))
    begin
      // manual mode keeps the last value once enabled; others clear
      next_current_result = `RESULT_RESET;
    end
    // per-channel dropout timer; the companion is not looked at
    next_disconnect_req = 1'b0;
    next_low_count      = 32'h0;
    if (status.powered && below_thr)
    begin
      if (low_count >= `DISCONNECT_CYCLES - 1)
      begin
        next_disconnect_req = 1'b1;
        next_low_count      = low_count;
      end
      else
      begin
        next_low_count = low_count + 32'h1;
      end
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      current_result <= `RESULT_RESET;
      enabled_once   <= 1'b0;
      low_count      <= 32'h0;
      disconnect_req <= 1'b0;
    end
    else if (clk_en)
    begin
      current_result <= next_current_result;
      enabled_once   <= next_enabled_once;
      low_count      <= next_low_count;
      disconnect_req <= next_disconnect_req;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  AST_OFF_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && status.mode == MODE_OFF |=> current_result == 14'h0000)
    else $error("off channel result not zero");
  AST_SEMI_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && status.mode == MODE_SEMI_AUTO && !status.powered && !status.detect_valid
    |=> current_result == 14'h0000)
    else $error("semi-auto invalid channel result not zero");
  AST_REFRESH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && status.powered && refresh_tick && status.mode != MODE_OFF
    |=> current_result == $past(adc_code))
    else $error("powered channel result not refreshed");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && status.mode == MODE_MANUAL && enabled_once && !status.powered
    |=> $stable(current_result))
    else $error("manual mode result not held");
  AST_DISC_CAUSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(disconnect_req) |-> $past(status.powered) && $past(below_thr))
    else $error("disconnect without low current");
  COV_DISC: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(disconnect_req));
  COV_HOLD: cover property (@(posedge clk_sys) disable iff (!rst_n)
    status.mode == MODE_MANUAL && enabled_once && !status.powered);

endmodule
`default_nettype wire

// >>> design/port_telemetry_readout.sv
// supply voltage and channel current results read over the management bus
`timescale 1ns/1ps
`default_nettype none
`include "telemetry_consts.svh"

module port_telemetry_readout
  import telemetry_pkg::*;
(
  // clock, reset, enable
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  // converter results
  input  wire logic [`RESULT_WIDTH-1:0]     supply_voltage_code,
  input  wire logic [4*`RESULT_WIDTH-1:0]   channel_adc_codes,
  // channel status and configuration
  input  wire telemetry_pkg::chan_status_t  channel_status [4],
  input  wire logic [3:0]                   disconnect_threshold_select,
  // management bus byte interface
  input  wire telemetry_pkg::mgmt_req_t     mgmt_req,
  output telemetry_pkg::mgmt_rsp_t          mgmt_rsp,
  // per-channel disconnect requests
  output logic [3:0]                        disconnect_req
);
  import telemetry_pkg::*;

  // ***************************************************************
  // refresh timer shared by all channels
  // ***************************************************************
  logic [31:0] refresh_count;        // cycles since last refresh
  logic [31:0] next_refresh_count;
  logic        refresh_tick;         // one-cycle refresh strobe
  logic        next_refresh_tick;

  always_comb
  begin
    // one strobe every 100 ms of enabled clock
    next_refresh_tick  = 1'b0;
    next_refresh_count = refresh_count + 32'h1;
    if (refresh_count >= `REFRESH_CYCLES - 1)
    begin
      next_refresh_count = 32'h0;
      next_refresh_tick  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // first strobe lands right after reset, so results are not stale for 100 ms
      refresh_count <= 32'(`REFRESH_CYCLES - 1);
      refresh_tick  <= 1'b0;
    end
    else if (clk_en)
    begin
      refresh_count <= next_refresh_count;
      refresh_tick  <= next_refresh_tick;
    end
  end

  // ***************************************************************
  // supply voltage result: any mode, straight 14-bit code
  // ***************************************************************
  logic [`RESULT_WIDTH-1:0] input_supply_voltage_result;
  logic [`RESULT_WIDTH-1:0] next_supply;

  always_comb
  begin
    // code times 3.662 mV, no mode dependence
    next_supply = refresh_tick ? supply_voltage_code
                               : input_supply_voltage_result;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      input_supply_voltage_result <= `RESULT_RESET;
    end
    else if (clk_en)
    begin
      input_supply_voltage_result <= next_supply;
    end
  end

  // ***************************************************************
  // channel trackers
  // ***************************************************************
  logic [`RESULT_WIDTH-1:0] current_result [4];  // unsigned 70.19 uA steps
  logic [3:0]               chan_disc;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_chan
      channel_current_tracker u_tracker (
        .clk_sys                    (clk_sys),
        .rst_n                      (rst_n),
        .clk_en                     (clk_en),
        .status                     (channel_status[gi]),
        .disconnect_threshold_select(disconnect_threshold_select[gi]),
        .adc_code                   (channel_adc_codes[gi*`RESULT_WIDTH +: `RESULT_WIDTH]),
        .refresh_tick               (refresh_tick),
        .current_result             (current_result[gi]),
        .disconnect_req             (chan_disc[gi])
      );
    end
  endgenerate

  // ***************************************************************
  // read engine: latch the word at command, send low then high
  // ***************************************************************
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_LOW,
    RD_HIGH
  } rd_state_t;

  rd_state_t   rd_state;            // byte position in the transfer
  rd_state_t   next_rd_state;
  logic [15:0] shadow;              // word frozen for a coherent pair
  logic [15:0] next_shadow;
  logic [15:0] sel_word;            // word named by the command
  logic        sel_hit;             // command is one of ours
  mgmt_rsp_t   next_rsp;
  logic [3:0]  next_disc;

  always_comb
  begin
    // upper two bits always zero so the pair forms the code
    sel_hit  = 1'b1;
    sel_word = 16'h0000;
    case (mgmt_req.command)
      `CMD_SUPPLY_VOLTAGE:    sel_word = {2'b00, input_supply_voltage_result};
      `CMD_CHANNEL_ONE_CUR:   sel_word = {2'b00, current_result[0]};
      `CMD_CHANNEL_TWO_CUR:   sel_word = {2'b00, current_result[1]};
      `CMD_CHANNEL_THREE_CUR: sel_word = {2'b00, current_result[2]};
      `CMD_CHANNEL_FOUR_CUR:  sel_word = {2'b00, current_result[3]};
      default:                sel_hit  = 1'b0;
    endcase
    next_rd_state = rd_state;
    next_shadow   = shadow;
    next_rsp      = mgmt_rsp;
    next_rsp.valid = 1'b0;
    next_disc     = chan_disc;
    if (mgmt_req.start)
    begin
      // a new command restarts the pair if it hits; a miss goes idle
      next_shadow   = sel_word;
      next_rsp.hit  = sel_hit;
      next_rsp.data = 8'h00;
      next_rd_state = sel_hit ? RD_LOW : RD_IDLE;
    end
    else if (mgmt_req.next_byte)
    begin
      case (rd_state)
        RD_LOW:
        begin
          next_rsp.valid = 1'b1;
          next_rsp.data  = shadow[7:0];
          next_rd_state  = RD_HIGH;
        end
        RD_HIGH:
        begin
          next_rsp.valid = 1'b1;
          next_rsp.data  = shadow[15:8];
          next_rd_state  = RD_IDLE;
        end
        default:
        begin
          // extra reads past the pair return zero
          next_rsp.valid = 1'b1;
          next_rsp.data  = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_state       <= RD_IDLE;
      shadow         <= 16'h0000;
      mgmt_rsp       <= '0;
      disconnect_req <= 4'h0;
    end
    else if (clk_en)
    begin
      rd_state       <= next_rd_state;
      shadow         <= next_shadow;
      mgmt_rsp       <= next_rsp;
      disconnect_req <= next_disc;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  AST_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_state == RD_IDLE && $past(rd_state) == RD_HIGH && mgmt_rsp.valid
    |-> mgmt_rsp.data[7:6] == 2'b00)
    else $error("upper result bits not zero");
  AST_LOW_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && rd_state == RD_LOW && mgmt_req.next_byte && !mgmt_req.start
    |=> mgmt_rsp.valid && mgmt_rsp.data == $past(shadow[7:0]) && rd_state == RD_HIGH)
    else $error("low byte not sent first");
  AST_HIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && mgmt_req.start && mgmt_req.command == 8'h38
    |=> mgmt_rsp.hit && shadow[13:0] == $past(current_result[2]))
    else $error("channel three command not decoded");
  AST_TICK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    refresh_tick |-> refresh_count == 32'h0)
    else $error("refresh strobe misaligned");
  AST_SUPPLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && refresh_tick |=> input_supply_voltage_result == $past(supply_voltage_code))
    else $error("supply result not updated");
  COV_SUPPLY_READ: cover property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_req.start && mgmt_req.command == 8'h2e ##[1:20] rd_state == RD_HIGH);
  COV_CHAN_READ: cover property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_req.start && mgmt_req.command == 8'h3c);
  COV_MISS: cover property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_req.start && mgmt_req.command == 8'h2f);

endmodule
`default_nettype wire

// >>> design/telemetry_consts.svh
// constants for the supply and channel telemetry readout
`ifndef TELEMETRY_CONSTS_SVH
`define TELEMETRY_CONSTS_SVH

// ***************************************************************
// command codes of the read-only results
// ***************************************************************
`define CMD_SUPPLY_VOLTAGE     8'h2e
`define CMD_CHANNEL_ONE_CUR    8'h30
`define CMD_CHANNEL_TWO_CUR    8'h34
`define CMD_CHANNEL_THREE_CUR  8'h38
`define CMD_CHANNEL_FOUR_CUR   8'h3c

// ***************************************************************
// field layout and reset values
// ***************************************************************
`define RESULT_WIDTH           14
`define RESULT_RESET           14'h0000
`define HIGH_BYTE_CODE_BITS    6

// ***************************************************************
// timing: refresh period and disconnect windows, in microseconds
// ***************************************************************
`define CLK_FREQ_MHZ           40
`define REFRESH_PERIOD_US      100000
`define REFRESH_CYCLES         (`REFRESH_PERIOD_US * `CLK_FREQ_MHZ)
`define DROPOUT_TIME_US        300000
`define SIGNATURE_HOLD_US      60
`define DISCONNECT_CYCLES      ((`DROPOUT_TIME_US + `SIGNATURE_HOLD_US) * `CLK_FREQ_MHZ)

`endif

// >>> design/telemetry_pkg.sv
// types shared by the telemetry readout design
package telemetry_pkg;

  // ***************************************************************
  // channel operating modes
  // ***************************************************************
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_MANUAL,
    MODE_SEMI_AUTO,
    MODE_AUTO
  } chan_mode_t;

  // ***************************************************************
  // per-channel status carried from the port control logic
  // ***************************************************************
  typedef struct packed {
    chan_mode_t  mode;              // operating mode
    logic        powered;           // channel power switched on
    logic        det_class_enable;  // detection and class enabled
    logic        detect_valid;      // last detection result is good
    logic        below_high_thr;    // current below 6.5 mA level
    logic        below_low_thr;     // current below 4.5 mA level
  } chan_status_t;

  // ***************************************************************
  // management bus read request and response byte
  // ***************************************************************
  typedef struct packed {
    logic        start;             // new command byte accepted
    logic [7:0]  command;           // command code
    logic        next_byte;         // host asks for the next data byte
  } mgmt_req_t;

  typedef struct packed {
    logic        valid;             // data byte holds a reply byte
    logic [7:0]  data;              // reply byte
    logic        hit;               // command names a result here
  } mgmt_rsp_t;

endpackage

// >>> sim/mgmt_host_model.sv
// host side of the management bus: issues commands and collects reply bytes
`timescale 1ns/1ps
`default_nettype none

module mgmt_host_model
  import telemetry_pkg::*;
(
  // clock
  input  wire logic                      clk_sys,
  // byte interface towards the readout
  output var  telemetry_pkg::mgmt_req_t  mgmt_req,
  input  wire telemetry_pkg::mgmt_rsp_t  mgmt_rsp
);
  import telemetry_pkg::*;

  // ***************************************************************
  // idle request
  // ***************************************************************
  initial
  begin
    mgmt_req = '0;
  end

  // ***************************************************************
  // one command with n reply bytes, driven on falling edges
  // ***************************************************************
  // command stays on the lines after start so nothing floats mid-transfer
  task automatic read_cmd(input logic [7:0] cmd, input bit do_start, input int n,
                          output logic hit, output logic [23:0] bytes,
                          output logic [2:0] valids);
    int i;
    bytes  = '0;
    valids = '0;
    @(negedge clk_sys);
    mgmt_req.command = cmd;
    mgmt_req.start   = do_start;
    if (do_start)
    begin
      @(negedge clk_sys);
      mgmt_req.start = 1'b0;
    end
    hit = mgmt_rsp.hit;
    // n bytes are fetched, low byte arrives first
    for (i = 0; i < n; i++)
    begin
      mgmt_req.next_byte = 1'b1;
      @(negedge clk_sys);
      bytes[i*8+:8] = mgmt_rsp.data;
      valids[i]     = mgmt_rsp.valid;
    end
    mgmt_req.next_byte = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the telemetry readout, driven through its top
`timescale 1ns/1ps
`default_nettype none
`include "telemetry_consts.svh"

module tb;
  import telemetry_pkg::*;

  // ***************************************************************
  // signals
  // ***************************************************************
  logic                      clk_sys;      // 40 MHz clock
  logic                      rst_n;        // async reset
  mgmt_req_t                 mgmt_req;     // from host model
  mgmt_rsp_t                 mgmt_rsp;     // to host model
  chan_status_t              top_status [4];
  logic [3:0]                top_disc;     // top disconnect requests
  logic [13:0]               supply_code;  // supply converter code
  logic [55:0]               adc_codes;    // channel codes, channel one low
  logic [15:0]               word;         // assembled reply word
  logic [15:0]               exp_w [8];    // expected words of the sweep
  int                        error_cnt;    // mismatches
  int                        num_checks;   // comparisons
  logic                      hit;          // hit seen by host
  logic [23:0]               bytes;        // reply bytes
  logic [2:0]                valids;       // reply valids
  logic [7:0]                cmds [8];     // command sweep

  `define CHECK(nm, e, g) check_val(nm, 16'(e), 16'(g))

  // ***************************************************************
  // clock and instances
  // ***************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // top: the first refresh strobe follows each reset, so each case restarts it
  port_telemetry_readout dut_u (
    .clk_sys                     (clk_sys),
    .rst_n                       (rst_n),
    .clk_en                      (1'b1),
    .supply_voltage_code         (supply_code),
    .channel_adc_codes           (adc_codes),
    .channel_status              (top_status),
    .disconnect_threshold_select (4'h5),
    .mgmt_req                    (mgmt_req),
    .mgmt_rsp                    (mgmt_rsp),
    .disconnect_req              (top_disc)
  );

  mgmt_host_model host_u (
    .clk_sys  (clk_sys),
    .mgmt_req (mgmt_req),
    .mgmt_rsp (mgmt_rsp)
  );

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic chan_status_t mk(chan_mode_t m, logic pw, logic dce, logic dv);
    chan_status_t s;
    s = '0;
    s.mode = m;
    s.powered = pw;
    s.det_class_enable = dce;
    s.detect_valid = dv;
    return s;
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // reset mid-run with new inputs; the refresh lands two edges after release
  task automatic restart(input chan_status_t st, input logic [55:0] codes,
                         input logic [13:0] sup);
    @(negedge clk_sys);
    rst_n = 1'b0;
    for (int c = 0; c < 4; c++)
      top_status[c] = st;
    adc_codes   = codes;
    supply_code = sup;
    @(negedge clk_sys);
    `CHECK("rst_rsp", 10'h000, mgmt_rsp);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
  endtask

  // one two-byte read, low byte first
  task automatic read_word(input logic [7:0] cmd);
    host_u.read_cmd(cmd, 1'b1, 2, hit, bytes, valids);
    word = bytes[15:0];
  endtask

  // ***************************************************************
  // channel rows: status at refresh, status after, code in, result out
  // ***************************************************************
  typedef struct {
    chan_status_t st0;  // status while the refresh lands
    chan_status_t st1;  // status afterwards
    logic [13:0]  adc;
    logic [13:0]  exp;
  } row_t;

  row_t rows [8];

  initial
  begin
    rows[0] = '{mk(MODE_AUTO, 1, 1, 1), mk(MODE_AUTO, 1, 1, 1), 14'h1abc, 14'h1abc};
    rows[1] = '{mk(MODE_OFF, 0, 1, 1), mk(MODE_OFF, 0, 1, 1), 14'h1abc, 14'h0000};
    rows[2] = '{mk(MODE_AUTO, 1, 1, 1), mk(MODE_SEMI_AUTO, 0, 0, 1), 14'h0155, 14'h0000};
    rows[3] = '{mk(MODE_AUTO, 1, 1, 1), mk(MODE_SEMI_AUTO, 0, 1, 0), 14'h3fff, 14'h0000};
    rows[4] = '{mk(MODE_AUTO, 1, 1, 1), mk(MODE_OFF, 0, 1, 1), 14'h0aaa, 14'h0000};
    rows[5] = '{mk(MODE_MANUAL, 1, 0, 0), mk(MODE_MANUAL, 0, 0, 0), 14'h0aaa, 14'h0aaa};
    rows[6] = '{mk(MODE_AUTO, 1, 1, 1), mk(MODE_AUTO, 1, 1, 1), 14'h3fff, 14'h3fff};
    rows[7] = '{mk(MODE_SEMI_AUTO, 1, 1, 1), mk(MODE_SEMI_AUTO, 1, 1, 1), 14'h0155, 14'h0155};
  end

  // ***************************************************************
  // watchdog: the whole run needs well under a thousand cycles
  // ***************************************************************
  initial
  begin
    #(25 * 4000);
    error_cnt++;
    print_verdict();
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial
  begin
    error_cnt  = 0;
    num_checks = 0;
    rst_n       = 1'b0;
    adc_codes   = 56'h0;
    supply_code = 14'h0000;
    for (int c = 0; c < 4; c++)
      top_status[c] = mk(MODE_AUTO, 1, 1, 1);
    cmds = '{`CMD_SUPPLY_VOLTAGE, `CMD_CHANNEL_ONE_CUR, `CMD_CHANNEL_TWO_CUR,
             `CMD_CHANNEL_THREE_CUR, `CMD_CHANNEL_FOUR_CUR, 8'h2f, 8'h32, 8'h3e};
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;

    // channel rows: refresh after reset, then change status, read back
    for (int i = 0; i < 8; i++)
    begin
      restart(rows[i].st0, {4{rows[i].adc}}, ~rows[i].adc);
      for (int c = 0; c < 4; c++)
        top_status[c] = rows[i].st1;
      repeat (2) @(negedge clk_sys);
      read_word(cmds[1 + i % 4]);
      `CHECK("chan_result", rows[i].exp, word);
      read_word(`CMD_SUPPLY_VOLTAGE);
      `CHECK("supply_result", supply_code, word);
    end

    // distinct codes per channel, three bytes, mapped and unmapped commands
    restart(mk(MODE_AUTO, 1, 1, 1), {14'h3fff, 14'h1555, 14'h0aaa, 14'h2001}, 14'h2abc);
    exp_w = '{16'h2abc, 16'h2001, 16'h0aaa, 16'h1555, 16'h3fff, 16'h0000, 16'h0000,
              16'h0000};
    for (int k = 0; k < 8; k++)
    begin
      host_u.read_cmd(cmds[k], 1'b1, 3, hit, bytes, valids);
      `CHECK("hit", (k < 5), hit);
      `CHECK("low_and_high", exp_w[k], bytes[15:0]);
      `CHECK("high_top_bits", 2'b00, bytes[15:14]);
      `CHECK("third_byte", 8'h00, bytes[23:16]);
      `CHECK("valids", 3'b111, valids);
      // valid drops one cycle after the last reply byte
      @(negedge clk_sys);
      `CHECK("valid_drops", 1'b0, mgmt_rsp.valid);
    end

    // next byte with no start after an unknown command reads zero
    host_u.read_cmd(8'h00, 1'b0, 2, hit, bytes, valids);
    `CHECK("no_start_bytes", 16'h0000, bytes[15:0]);
    `CHECK("no_start_valids", 3'b011, valids);
    `CHECK("disconnect_idle", 4'h0, top_disc);
    print_verdict();
  end
endmodule
`default_nettype wire
